// ### nov_pkg.sv
// Purpose: Shared constants and types of the neutral overvoltage stage.
// Assumes: Voltages in 0.01 % of nominal line-to-line voltage, times in 5 ms ticks.
// Notes:   Word addresses on the plain register port are 5 bits wide.
package nov_pkg;
  // Clock and processing tick
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_TIME_NS    = 5000000;
  localparam int          TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int          TICK_MS         = 5;
  localparam int          TICK_CNT_W      = 20;
  // Data widths
  localparam int          DATA_W          = 16;
  localparam int          TIME_W          = 19;
  localparam int          ADDR_W          = 5;
  localparam int          GRP_W           = 3;
  localparam int          NUM_GROUPS      = 8;
  // Register word addresses
  localparam logic [4:0]  ADDR_CTRL       = 5'h00;
  localparam logic [4:0]  ADDR_OP_DELAY   = 5'h01;
  localparam logic [4:0]  ADDR_TIME_DIAL  = 5'h02;
  localparam logic [4:0]  ADDR_MULT       = 5'h03;
  localparam logic [4:0]  ADDR_REL_DELAY  = 5'h04;
  localparam logic [4:0]  ADDR_GROUP      = 5'h05;
  localparam logic [4:0]  ADDR_ACT_THR    = 5'h06;
  localparam logic [4:0]  ADDR_THR_BASE   = 5'h08;
  localparam logic [4:0]  ADDR_STATUS     = 5'h10;
  localparam logic [4:0]  ADDR_RATIO      = 5'h11;
  localparam logic [4:0]  ADDR_EXPECTED   = 5'h12;
  localparam logic [4:0]  ADDR_REMAIN     = 5'h13;
  localparam logic [4:0]  ADDR_MEAS       = 5'h14;
  // Control word field positions
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_FORCE_LSB  = 4;
  localparam int          CTRL_SEL_LSB    = 8;
  localparam int          CTRL_INVERSE_TIME_MODE_BIT   = 12;
  localparam int          CTRL_DLYREL_BIT = 13;
  localparam int          CTRL_TRST_BIT   = 14;
  localparam int          CTRL_CONT_BIT   = 15;
  // Setting defaults and limits
  localparam logic [15:0] THR_DEF         = 16'h07D0;
  localparam logic [15:0] THR_MIN         = 16'h0064;
  localparam logic [18:0] OP_DELAY_DEF    = 19'h00008;
  localparam logic [12:0] K_DEF           = 13'h0005;
  localparam logic [11:0] MULT_DEF        = 12'h064;
  localparam logic [13:0] REL_DEF         = 14'h000C;
  localparam logic [18:0] TIME_MAX        = 19'h57E40;
  localparam logic [31:0] RATIO_MAX       = 32'h0001E848;
  localparam logic [31:0] PCT_FULL        = 32'h00000064;
  localparam logic [31:0] RESET_PCT       = 32'h00000061;
  localparam logic [31:0] INVERSE_TIME_MODE_NUM_SCALE  = 32'h00004E20;
  localparam logic [31:0] INV_SQRT3_Q16   = 32'h000093CD;
  localparam int          Q16_SHIFT       = 16;
  // Stage mode
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLOCKED = 3'h3, MODE_OFF = 3'h4
  } nov_mode_type;
  // Forced status
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'h0, FORCE_START = 2'h1, FORCE_TRIP = 2'h2, FORCE_BLOCKED = 2'h3
  } nov_force_type;
  // Input selection and measuring-now indication
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0, SEL_CALC = 2'h1, SEL_CH3 = 2'h2, SEL_CH4 = 2'h3
  } nov_sel_type;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_TRIP = 5'h04, ST_RELEASE = 5'h08, ST_BLOCKED = 5'h10
  } nov_state_type;
endpackage : nov_pkg

// ### nov_thr_if.sv
// Purpose: Carrier between the stage and its per-group threshold store.
// Assumes: One write port and one registered read port.
// Notes:   Read data follow the index by one clock.
interface nov_thr_if;
  import nov_pkg::*;
  logic              wr_en;
  logic [GRP_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [GRP_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_data;
  modport mem  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
  modport user (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
endinterface : nov_thr_if

// ### nov_thr_mem.sv
// Purpose: Pick-up threshold for each setting group.
// Assumes: All entries reset to the default threshold.
// Notes:   Read data come from a register.
module nov_thr_mem
  import nov_pkg::*;
(
  input  wire logic  i_mclk,
  input  wire logic  i_sys_rst,
  input  wire logic  i_ce,
  nov_thr_if.mem     thr
);
  logic [DATA_W-1:0] mem_q [NUM_GROUPS];

  // One stored threshold per group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_entry
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        mem_q[g] <= THR_DEF;
      end else if (i_ce && thr.wr_en && (thr.wr_idx == GRP_W'(g))) begin
        mem_q[g] <= thr.wr_data;
      end
    end
  end

  // Registered read port
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      thr.rd_data <= THR_DEF;
    end else if (i_ce) begin
      thr.rd_data <= mem_q[thr.rd_idx];
    end
  end
endmodule : nov_thr_mem

// ### nov_stage.sv
// Purpose: Neutral overvoltage stage with pick-up, blocking, timers and status.
// Assumes: Phase phasors and residual magnitudes are refreshed each 5 ms tick.
// Notes:   Tick events run a three-step pipeline: sample, pick-up, sequencer.
// Function
// - Calculated option sums the three phase voltages and takes one third.
// - Neutral voltage is scaled so a full earth fault reads 100 %.
// - Inputs are fundamental magnitudes refreshed every 5 ms.
// - Selector offers none, calculated, channel three or channel four.
// - Channel three or four accepted only when set to residual mode.
// - No selection falls back to calculated, else reports nothing available.
// - Mode On, Blocked, Test, Test/Blocked or Off; mode in effect readable.
// - Forcing drives status to Normal, Start, Trip or Blocked.
// - General settings stay put when the setting group changes.
// - Pick-up threshold follows the active setting group while running.
// - Threshold in 0.01 % steps, default 20.00 %.
// - Pick-up activates when measured magnitude exceeds threshold.
// - Pick-up releases below 97 % of threshold, and at once in Off mode or with no input measured.
// - Measured-to-threshold ratio always readable at 0.01 resolution.
// - Remaining time to trip readable as signed 5 ms steps.
// - Inverse-time operating time recomputed from present voltage.
// - Blocking input sampled at start of each processing cycle.
// - Unblocked pick-up raises START and starts timing.
// - Blocked pick-up raises BLOCKED instead and moves on to START once the block drops.
// - Blocking during START clears it and runs release handling.
// - Instant trip with START; definite time trips after set delay.
// - Inverse time is dial over multiplier times (ratio minus one).
// - Release delay 0.06 s with hold, timer-reset and continue options.
//
// Local design decisions: the plain strobed port and the register offsets.
module nov_stage
  import nov_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_ce,
  input  wire logic [ADDR_W-1:0]        i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output      logic [31:0]              o_rdata,
  input  wire logic signed [DATA_W-1:0] i_ul1_re,
  input  wire logic signed [DATA_W-1:0] i_ul1_im,
  input  wire logic signed [DATA_W-1:0] i_ul2_re,
  input  wire logic signed [DATA_W-1:0] i_ul2_im,
  input  wire logic signed [DATA_W-1:0] i_ul3_re,
  input  wire logic signed [DATA_W-1:0] i_ul3_im,
  input  wire logic [DATA_W-1:0]        i_ch3_mag,
  input  wire logic [DATA_W-1:0]        i_ch4_mag,
  input  wire logic                     i_ch3_residual,
  input  wire logic                     i_ch4_residual,
  input  wire logic                     i_ln_connected,
  input  wire logic                     i_block,
  output      logic                     o_tick,
  output      logic                     o_start,
  output      logic                     o_trip,
  output      logic                     o_blocked,
  output      logic                     o_test
);
  nov_thr_if thr ();

  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic                  ev1_q, ev2_q, ev3_q;
  logic [15:0]           ctrl_q;
  logic [TIME_W-1:0]     op_delay_q;
  logic [12:0]           k_q;
  logic [11:0]           mult_q;
  logic [13:0]           rel_delay_q;
  logic [GRP_W-1:0]      group_q;
  logic [DATA_W-1:0]     meas_q, thr_q;
  logic                  blk_q, pickup_q, rel_by_block_q;
  nov_sel_type           now_q;
  nov_state_type         state_q, state_d;
  logic [TIME_W-1:0]     elapsed_q, elapsed_d;
  logic [13:0]           rel_cnt_q, rel_cnt_d;
  nov_mode_type          mode;
  nov_force_type         force_sel;
  nov_sel_type           sel, now_d;
  logic [17:0]           ax, ay, mx, mn;
  logic signed [17:0]    sum_re, sum_im;
  logic [31:0]           calc_mag, ratio, inverse_time_mode_t, den, mag_d;
  logic [TIME_W-1:0]     expected, elapsed_nxt;
  logic signed [TIME_W:0] remain;
  logic                  blk_eff, mode_live, start_raw;

  nov_thr_mem u_thr_mem (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .thr       (thr.mem)
  );

  assign mode      = nov_mode_type'(ctrl_q[CTRL_MODE_LSB +: 3]);
  assign force_sel = nov_force_type'(ctrl_q[CTRL_FORCE_LSB +: 2]);
  assign sel       = nov_sel_type'(ctrl_q[CTRL_SEL_LSB +: 2]);
  assign mode_live = (mode != MODE_OFF);
  assign blk_eff   = blk_q || (mode == MODE_BLOCKED) || (mode == MODE_TEST_BLOCKED);

  // Processing tick divider, one pulse each 5 ms
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_q <= '0;
      o_tick     <= 1'b0;
    end else if (i_ce) begin
      o_tick     <= (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Pipeline of the tick: sample, pick-up, sequencer
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev1_q <= 1'b0;
      ev2_q <= 1'b0;
      ev3_q <= 1'b0;
    end else if (i_ce) begin
      ev1_q <= o_tick;
      ev2_q <= ev1_q;
      ev3_q <= ev2_q;
    end
  end

  // Zero-sequence magnitude from the phase phasors, approximated max plus 3/8 min
  always_comb begin
    sum_re   = 18'(i_ul1_re) + 18'(i_ul2_re) + 18'(i_ul3_re);
    sum_im   = 18'(i_ul1_im) + 18'(i_ul2_im) + 18'(i_ul3_im);
    ax       = sum_re[17] ? 18'(-sum_re) : 18'(sum_re);
    ay       = sum_im[17] ? 18'(-sum_im) : 18'(sum_im);
    mx       = (ax > ay) ? ax : ay;
    mn       = (ax > ay) ? ay : ax;
    // One third times root three puts it on line-to-line level
    calc_mag = ((32'(mx) + 32'(mn >> 2) + 32'(mn >> 3)) * INV_SQRT3_Q16) >> Q16_SHIFT;
  end

  // Input channel actually measured, with fallback
  always_comb begin
    now_d = SEL_NONE;
    mag_d = '0;
    unique case (sel)
      SEL_CALC: begin
        now_d = SEL_CALC;
      end
      SEL_CH3: begin
        now_d = i_ch3_residual ? SEL_CH3 : SEL_NONE;
      end
      SEL_CH4: begin
        now_d = i_ch4_residual ? SEL_CH4 : SEL_NONE;
      end
      SEL_NONE: begin
        now_d = i_ln_connected ? SEL_CALC : SEL_NONE;
      end
    endcase
    unique case (now_d)
      SEL_CALC: mag_d = calc_mag;
      SEL_CH3:  mag_d = 32'(i_ch3_mag);
      SEL_CH4:  mag_d = 32'(i_ch4_mag);
      SEL_NONE: mag_d = '0;
    endcase
  end

  // Step one: sample magnitude, group threshold and blocking input
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meas_q <= '0;
      thr_q  <= THR_DEF;
      blk_q  <= 1'b0;
      now_q  <= SEL_NONE;
    end else if (i_ce && ev1_q) begin
      meas_q <= (mag_d > 32'hFFFF) ? 16'hFFFF : mag_d[DATA_W-1:0];
      thr_q  <= thr.rd_data;
      blk_q  <= i_block;
      now_q  <= now_d;
    end
  end

  // Step two: pick-up with fixed 97 % reset ratio
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pickup_q <= 1'b0;
    end else if (i_ce && ev2_q) begin
      if (!mode_live || (now_q == SEL_NONE)) begin
        pickup_q <= 1'b0;
      end else if (meas_q > thr_q) begin
        pickup_q <= 1'b1;
      end else if ((32'(meas_q) * PCT_FULL) < (32'(thr_q) * RESET_PCT)) begin
        pickup_q <= 1'b0;
      end
    end
  end

  // Ratio and expected operating time, following the present voltage
  always_comb begin
    ratio  = (32'(meas_q) * PCT_FULL) / 32'(thr_q);
    if (ratio > RATIO_MAX) begin
      ratio = RATIO_MAX;
    end
    den    = (ratio > PCT_FULL) ? 32'(mult_q) * (ratio - PCT_FULL) : 32'h1;
    inverse_time_mode_t = (ratio > PCT_FULL) ? (32'(k_q) * INVERSE_TIME_MODE_NUM_SCALE) / den : 32'(TIME_MAX);
    if (inverse_time_mode_t > 32'(TIME_MAX)) begin
      inverse_time_mode_t = 32'(TIME_MAX);
    end
    expected = ctrl_q[CTRL_INVERSE_TIME_MODE_BIT] ? inverse_time_mode_t[TIME_W-1:0] : op_delay_q;
    elapsed_nxt = (elapsed_q == TIME_MAX) ? elapsed_q : elapsed_q + 1'b1;
    remain   = $signed({1'b0, expected}) - $signed({1'b0, elapsed_q});
  end

  // Step three: sequencer next state and timers
  always_comb begin
    state_d   = state_q;
    elapsed_d = elapsed_q;
    rel_cnt_d = rel_cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        elapsed_d = '0;
        rel_cnt_d = '0;
        if (pickup_q && blk_eff) begin
          state_d = ST_BLOCKED;
        end else if (pickup_q) begin
          state_d = (expected == '0) ? ST_TRIP : ST_START;
        end
      end
      ST_START: begin
        if (blk_eff || !pickup_q) begin
          state_d   = ST_RELEASE;
          rel_cnt_d = '0;
          elapsed_d = ctrl_q[CTRL_TRST_BIT] ? elapsed_q : '0;
        end else begin
          elapsed_d = elapsed_nxt;
          state_d   = (elapsed_nxt >= expected) ? ST_TRIP : ST_START;
        end
      end
      ST_RELEASE: begin
        rel_cnt_d = rel_cnt_q + 1'b1;
        if (ctrl_q[CTRL_CONT_BIT]) begin
          elapsed_d = elapsed_nxt;
        end
        if (pickup_q && !blk_eff) begin
          state_d   = ST_START;
          rel_cnt_d = '0;
        end else if (rel_cnt_d >= rel_delay_q) begin
          state_d   = ST_IDLE;
          elapsed_d = '0;
        end
      end
      ST_TRIP: begin
        if (!pickup_q || blk_eff) begin
          state_d   = ST_IDLE;
          elapsed_d = '0;
        end
      end
      ST_BLOCKED: begin
        if (!pickup_q) begin
          state_d = ST_IDLE;
        end else if (!blk_eff) begin
          state_d   = ST_START;
          elapsed_d = '0;
        end
      end
    endcase
    if (!mode_live) begin
      state_d   = ST_IDLE;
      elapsed_d = '0;
      rel_cnt_d = '0;
    end
  end

  // Sequencer registers, updated once per tick
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q        <= ST_IDLE;
      elapsed_q      <= '0;
      rel_cnt_q      <= '0;
      rel_by_block_q <= 1'b0;
    end else if (i_ce && ev3_q) begin
      state_q        <= state_d;
      elapsed_q      <= elapsed_d;
      rel_cnt_q      <= rel_cnt_d;
      if (state_q == ST_START) begin
        rel_by_block_q <= blk_eff;
      end
    end
  end

  // Status outputs with forcing override
  assign start_raw = (state_q == ST_START) || (state_q == ST_TRIP) ||
                     ((state_q == ST_RELEASE) && ctrl_q[CTRL_DLYREL_BIT] && !rel_by_block_q);
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_start   <= 1'b0;
      o_trip    <= 1'b0;
      o_blocked <= 1'b0;
      o_test    <= 1'b0;
    end else if (i_ce) begin
      o_test <= (mode == MODE_TEST) || (mode == MODE_TEST_BLOCKED);
      unique case (force_sel)
        FORCE_NORMAL: begin
          o_start   <= start_raw;
          o_trip    <= (state_q == ST_TRIP);
          o_blocked <= (state_q == ST_BLOCKED);
        end
        FORCE_START: begin
          o_start   <= 1'b1;
          o_trip    <= 1'b0;
          o_blocked <= 1'b0;
        end
        FORCE_TRIP: begin
          o_start   <= 1'b1;
          o_trip    <= 1'b1;
          o_blocked <= 1'b0;
        end
        FORCE_BLOCKED: begin
          o_start   <= 1'b0;
          o_trip    <= 1'b0;
          o_blocked <= 1'b1;
        end
      endcase
    end
  end

  // Register writes: general settings, timers, group choice
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q      <= 16'h6000;
      op_delay_q  <= OP_DELAY_DEF;
      k_q         <= K_DEF;
      mult_q      <= MULT_DEF;
      rel_delay_q <= REL_DEF;
      group_q     <= '0;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        ADDR_CTRL: begin
          ctrl_q[15:CTRL_INVERSE_TIME_MODE_BIT] <= i_wdata[15:CTRL_INVERSE_TIME_MODE_BIT];
          ctrl_q[CTRL_FORCE_LSB +: 2] <= i_wdata[CTRL_FORCE_LSB +: 2];
          if (i_wdata[CTRL_MODE_LSB +: 3] <= MODE_OFF) begin
            ctrl_q[CTRL_MODE_LSB +: 3] <= i_wdata[CTRL_MODE_LSB +: 3];
          end
          if (!((i_wdata[CTRL_SEL_LSB +: 2] == SEL_CH3) && !i_ch3_residual) &&
              !((i_wdata[CTRL_SEL_LSB +: 2] == SEL_CH4) && !i_ch4_residual)) begin
            ctrl_q[CTRL_SEL_LSB +: 2] <= i_wdata[CTRL_SEL_LSB +: 2];
          end
        end
        ADDR_OP_DELAY:  op_delay_q  <= (i_wdata[TIME_W-1:0] > TIME_MAX) ? TIME_MAX : i_wdata[TIME_W-1:0];
        ADDR_TIME_DIAL: k_q         <= i_wdata[12:0];
        ADDR_MULT:      mult_q      <= (i_wdata[11:0] == '0) ? 12'h001 : i_wdata[11:0];
        ADDR_REL_DELAY: rel_delay_q <= i_wdata[13:0];
        ADDR_GROUP:     group_q     <= i_wdata[GRP_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Threshold store: write by group address, read the active group
  assign thr.wr_en   = i_wr && (i_addr[ADDR_W-1:GRP_W] == ADDR_THR_BASE[ADDR_W-1:GRP_W]);
  assign thr.wr_idx  = i_addr[GRP_W-1:0];
  assign thr.wr_data = (i_wdata[DATA_W-1:0] < THR_MIN) ? THR_MIN : i_wdata[DATA_W-1:0];
  assign thr.rd_idx  = group_q;

  // Read port, data one cycle after the strobe, zero when unmapped
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        unique case (i_addr)
          ADDR_CTRL:      o_rdata <= 32'(ctrl_q);
          ADDR_OP_DELAY:  o_rdata <= 32'(op_delay_q);
          ADDR_TIME_DIAL: o_rdata <= 32'(k_q);
          ADDR_MULT:      o_rdata <= 32'(mult_q);
          ADDR_REL_DELAY: o_rdata <= 32'(rel_delay_q);
          ADDR_GROUP:     o_rdata <= 32'(group_q);
          ADDR_ACT_THR:   o_rdata <= 32'(thr_q);
          ADDR_STATUS:    o_rdata <= {16'h0000, 3'h0, state_q, mode, now_q, o_blocked, o_trip, o_start};
          ADDR_RATIO:     o_rdata <= ratio;
          ADDR_EXPECTED:  o_rdata <= 32'(expected);
          ADDR_REMAIN:    o_rdata <= ((state_q == ST_START) || (state_q == ST_RELEASE)) ? 32'(remain) : '0;
          ADDR_MEAS:      o_rdata <= 32'(meas_q);
          default:        o_rdata <= '0;
        endcase
      end
    end
  end

  // Checks
  sequence s_pick_free;
    ev3_q && i_ce && mode_live && pickup_q && !blk_eff && (state_q == ST_IDLE);
  endsequence
  sequence s_pick_blocked;
    ev3_q && i_ce && mode_live && pickup_q && blk_eff && (state_q == ST_IDLE);
  endsequence
  sequence s_block_in_start;
    ev3_q && i_ce && mode_live && blk_eff && (state_q == ST_START);
  endsequence

  a_start_on_pick: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pick_free |=> (state_q == ST_START) || (state_q == ST_TRIP)) else $error("pick-up without START");
  a_blocked_pick: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pick_blocked |=> (state_q == ST_BLOCKED) ##1 !start_raw) else $error("blocked pick-up not held");
  a_block_clears: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_block_in_start |=> (state_q == ST_RELEASE) && !start_raw) else $error("START kept under block");
  a_instant_trip: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    s_pick_free ##0 (expected == '0) |=> (state_q == ST_TRIP)) else $error("instant trip missing");
  a_pick_rise: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $rose(pickup_q) |-> (meas_q > thr_q)) else $error("pick-up without overvoltage");
  a_pick_fall: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    $fell(pickup_q) && mode_live && (now_q != SEL_NONE) |-> (32'(meas_q) * PCT_FULL) < (32'(thr_q) * RESET_PCT))
    else $error("pick-up dropped inside hysteresis");
  a_tick_gap: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_tick && i_ce |=> !ev3_q ##1 !ev3_q ##1 ev3_q [*1] ##1 !ev3_q) else $error("tick pipeline out of step");
  a_off_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (mode == MODE_OFF) && i_ce && ev3_q |=> (state_q == ST_IDLE) && (elapsed_q == '0)) else $error("Off mode active");
  a_force_trip: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (force_sel == FORCE_TRIP) && i_ce |=> o_trip && o_start && !o_blocked) else $error("forced trip not shown");
  a_no_u0: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (now_q == SEL_NONE) && ev2_q && i_ce |=> !pickup_q) else $error("pick-up with no residual");
endmodule : nov_stage

// ### nov_src_model.sv
// Purpose: Far side of the stage: residual magnitude source and blocking matrix.
// Assumes: New values are presented just after each tick.
// Notes:   Values stand for the whole tick so sampling never sees a change.
module nov_src_model
  import nov_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_tick,
  input  wire logic [DATA_W-1:0] i_mag_req,
  input  wire logic              i_blk_req,
  output      logic [DATA_W-1:0] o_ch3_mag,
  output      logic              o_block
);
  timeunit 1ns;
  timeprecision 1ps;
  // Refresh once per 5 ms tick
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ch3_mag <= 16'h0000;
      o_block   <= 1'b0;
    end else if (i_tick) begin
      o_ch3_mag <= i_mag_req;
      o_block   <= i_blk_req;
    end
  end
endmodule : nov_src_model

// ### nov_stage_tb.sv
// Purpose: Self-checking bench of the stage.
// Assumes: Short tick of 20 clocks.
// Notes:   Inputs change by non-blocking assignment after rising edges.
module nov_stage_tb
  import nov_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_mclk, i_sys_rst, i_wr, i_rd, o_tick, o_start, o_trip, o_blocked, o_test;
  logic              blk, res3, lnc, bk, ce;
  logic [ADDR_W-1:0] i_addr;
  logic [31:0]       i_wdata, o_rdata, v;
  logic [DATA_W-1:0] mag, ch3, ph;
  int                bad_count, checks, cyc;
  nov_src_model i_nov_src_model (.i_mclk(i_mclk), .i_rst(i_sys_rst), .i_tick(o_tick), .i_mag_req(mag),
    .i_blk_req(blk), .o_ch3_mag(ch3), .o_block(bk));
  nov_stage #(.TICK_CYCLES(20)) i_nov_stage (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ul1_re(ph),
    .i_ul1_im(16'h0000), .i_ul2_re(ph), .i_ul2_im(16'h0000), .i_ul3_re(ph), .i_ul3_im(16'h0000),
    .i_ch3_mag(ch3),
    .i_ch4_mag(mag), .i_ch3_residual(res3), .i_ch4_residual(res3), .i_ln_connected(lnc), .i_block(bk),
    .o_tick(o_tick), .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_test(o_test));
  // Comparison and report
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Bus cycles and tick waits
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_mclk); i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk); i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge i_mclk); i_rd <= 1'b1; i_addr <= a;
    @(posedge i_mclk); i_rd <= 1'b0;
    // Take the answer mid-cycle, then hand back on a rising edge
    @(negedge i_mclk);
    v = o_rdata;
    @(posedge i_mclk);
  endtask : rd
  task automatic tk(input int n);
    repeat (n) @(posedge i_mclk iff o_tick);
    repeat (6) @(posedge i_mclk);
  endtask : tk
  // Clock and cycle limit
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Scenario sequence
  initial begin
    {i_wr, i_rd, i_addr, i_wdata, blk, res3, lnc, mag, ph, bad_count, checks, cyc} = '0;
    ce = 1'b1;
    i_sys_rst = 1'b1;
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    tk(1);
    rd(ADDR_CTRL);    chk("ctrl", v, 32'h00006000);
    rd(ADDR_ACT_THR); chk("thr", v, 32'h000007D0);
    rd(ADDR_STATUS);  chk("none", v[4:3], 32'h0);
    lnc <= 1'b1; tk(1);
    rd(ADDR_STATUS);  chk("calc", v[4:3], 32'h1);
    wr(ADDR_CTRL, 32'h6200); rd(ADDR_CTRL); chk("refuse", v, 32'h00006000);
    res3 <= 1'b1;
    wr(ADDR_CTRL, 32'h6200); rd(ADDR_CTRL); chk("sel", v, 32'h00006200);
    wr(ADDR_OP_DELAY, 32'h2); mag <= 16'h07D0; tk(2);
    chk("eq", o_start, 1'b0);
    mag <= 16'h07D1; tk(1); chk("st", {o_start, o_trip}, 2'b10);
    tk(2); chk("tr", o_trip, 1'b1);
    mag <= 16'h0795; tk(2); chk("hold", o_trip, 1'b1);
    mag <= 16'h0793; tk(2); chk("rel", o_trip, 1'b0);
    mag <= 16'h09C4; tk(1); chk("st2", o_start, 1'b1);
    blk <= 1'b1; tk(1); chk("bst", o_start, 1'b0);
    blk <= 1'b0; mag <= 16'h0000; tk(16); blk <= 1'b1; mag <= 16'h09C4; tk(1);
    chk("blk", {o_start, o_blocked}, 2'b01);
    wr(ADDR_CTRL, 32'h6222); repeat (3) @(posedge i_mclk);
    chk("frc", {o_trip, o_test}, 2'b11);
    // Write under a low clock enable must not land
    ce <= 1'b0;
    wr(ADDR_GROUP, 32'h1);
    ce <= 1'b1;
    rd(ADDR_GROUP);   chk("ce", v, 32'h0);
    // Off mode with calculated input from equal in-phase phases
    wr(ADDR_CTRL, 32'h6104);
    ph <= 16'h03E8;
    tk(1);
    chk("off", {o_start, o_trip, o_blocked}, 3'b000);
    rd(ADDR_MEAS);    chk("u0", v, 32'h000006C4);
    tally_and_finish();
  end
endmodule : nov_stage_tb
